// ===== hw/ccsc_pkg.sv
// package for the codec clock-tree configuration block: register map, field layout,
// reset values, source codes and counts. assumes an 8-bit register port with 8-bit addresses.
package ccsc_pkg;

  // ==========================================================================
  // register offsets
  localparam logic [7:0] OFS_DIV_ENABLE   = 8'h45;
  localparam logic [7:0] OFS_CLKOUT_SRC   = 8'h46;
  localparam logic [7:0] OFS_CLOCK_OUTPUT_DIVIDE_VALUE   = 8'h47;
  localparam logic [7:0] OFS_CONV_CLK     = 8'h49;
  localparam logic [7:0] OFS_ADC_OVLD     = 8'h5b;

  // ==========================================================================
  // reset values and writable-bit masks (reserved bits store nothing, read zero)
  localparam logic [7:0] RST_DIV_ENABLE   = 8'h00;
  localparam logic [7:0] RST_CLKOUT_SRC   = 8'h00;
  localparam logic [7:0] RST_CLOCK_OUTPUT_DIVIDE_VALUE   = 8'h01;
  localparam logic [7:0] RST_CONV_CLK     = 8'h00;
  localparam logic [7:0] RST_ADC_OVLD     = 8'h00;
  localparam logic [7:0] MSK_DIV_ENABLE   = 8'h5f;
  localparam logic [7:0] MSK_CLKOUT_SRC   = 8'h07;
  localparam logic [7:0] MSK_CLOCK_OUTPUT_DIVIDE_VALUE   = 8'hff;
  localparam logic [7:0] MSK_CONV_CLK     = 8'hff;

  // ==========================================================================
  // divider enable register bit positions
  localparam int BIT_ADC_MOD_EN  = 6;
  localparam int BIT_DAC_MOD_EN  = 4;
  localparam int BIT_PRI_BCLK_EN = 3;
  localparam int BIT_SEC_BCLK_EN = 2;
  localparam int BIT_PRI_FS_EN   = 1;
  localparam int BIT_SEC_FS_EN   = 0;

  // clock output fields
  localparam int BIT_CLKOUT_EN   = 7;
  localparam int CLOCK_OUTPUT_DIVIDE_VALUE_W    = 7;
  localparam int CLKOUT_RATIO_W  = 8;
  localparam logic [7:0] CLKOUT_RATIO_ZERO = 8'h80;

  // converter clock fields
  localparam int BIT_FREQ_MODE_HI = 7;
  localparam int BIT_FREQ_MODE_LO = 6;
  localparam int BIT_SRC_AUTO_DIS = 5;
  localparam int BIT_SRC_MAN_SEL  = 4;
  localparam int BIT_EN_AUTO_DIS  = 3;
  localparam int BIT_MAN_EN       = 2;
  localparam int BIT_MAN_DIV_HI   = 1;
  localparam int BIT_MAN_DIV_LO   = 0;
  localparam int SAR_RATIO_W      = 4;
  localparam logic [1:0] FREQ_MODE_12M = 2'h3;

  // overload status fields
  localparam int BIT_OVLD_LATCH_LO = 6;
  localparam int BIT_OVLD_LIVE_LO  = 4;

  // ==========================================================================
  // clock output source codes; 6 and 7 are reserved and give a quiet source
  typedef enum logic [2:0] {
    CCSC_SRC_PLL   = 3'h0,
    CCSC_SRC_PBCLK = 3'h1,
    CCSC_SRC_SBCLK = 3'h2,
    CCSC_SRC_CONTROL_INTERFACE_CLOCK  = 3'h3,
    CCSC_SRC_OSC   = 3'h4,
    CCSC_SRC_DSP   = 3'h5
  } ccsc_src_t;

  // index of each synchronised source inside the tick vector
  localparam int NUM_SRC   = 7;
  localparam int IDX_AUDIO = 6;
  localparam int NUM_AUDIO_DIV = 6;
  localparam int NUM_AUTO_DIV  = 4;

endpackage

// ===== hw/ccsc_sync.sv
// three-flop synchroniser with a rising-edge tick for one pin-level clock.
// assumes the sampled clock is slow enough against clk_sys to be seen as levels.
`timescale 1ns/1ps
module ccsc_sync
  import ccsc_pkg::*;
(
  input  wire logic clk_sys,   // system clock
  input  wire logic rst_n,     // synchronised reset, active low
  input  wire logic async_in,  // pin level from another domain
  output logic      rise_tick  // one-cycle pulse on an accepted rising edge
);

  logic s1_r;
  logic s2_r;
  logic s3_r;
  logic lvl_r;

  // s1 feeds only s2; a change counts once s2 and s3 agree
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
    end
    else
    begin
      s1_r <= async_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      lvl_r     <= 1'b0;
      rise_tick <= 1'b0;
    end
    else
    begin
      rise_tick <= (s2_r == s3_r) && s3_r && !lvl_r;
      if (s2_r == s3_r)
      begin
        lvl_r <= s3_r;
      end
    end
  end

endmodule

// ===== hw/ccsc_divider.sv
// tick-counting clock divider: counts source ticks and forms a divided level and a
// period pulse, both from flops. assumes ratio is at least 1.
`timescale 1ns/1ps
module ccsc_divider #(
  parameter int RW = 10
) (
  input  wire logic          clk_sys,   // system clock
  input  wire logic          rst_n,     // synchronised reset, active low
  input  wire logic          enable,    // divider runs while high
  input  wire logic          tick,      // one pulse per source clock edge
  input  wire logic [RW-1:0] ratio,     // division ratio
  output logic               clk_out,   // divided clock level
  output logic               pulse_out  // one pulse per divided period
);

  logic [RW-1:0] cnt_r;
  logic [RW-1:0] cnt_nxt;
  logic [RW-1:0] high_len;

  always_comb
  begin
    high_len = ratio - (ratio >> 1);
    if (cnt_r >= ratio - {{(RW-1){1'b0}}, 1'b1})
      cnt_nxt = '0;
    else
      cnt_nxt = cnt_r + {{(RW-1){1'b0}}, 1'b1};
  end

  // disabled output sits low from a flop, so it never toggles or glitches
  // limitation: a ratio of 1 gives a steady high level, only the pulse carries the rate
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_r     <= '0;
      clk_out   <= 1'b0;
      pulse_out <= 1'b0;
    end
    else if (!enable)
    begin
      cnt_r     <= '0;
      clk_out   <= 1'b0;
      pulse_out <= 1'b0;
    end
    else
    begin
      pulse_out <= tick && (cnt_nxt == '0);
      if (tick)
      begin
        cnt_r   <= cnt_nxt;
        clk_out <= (cnt_nxt < high_len);
      end
    end
  end

endmodule

// ===== hw/ccsc_top.sv
// clock-tree configuration of an audio codec: divider enables, general-purpose clock
// output and converter clock, set through an 8-bit register port.
// assumes source clocks arrive as pin levels no faster than clk_sys/4, each level held for at least two clk_sys cycles.
//
// Overview of operation
// - adc modulator divider runs only when bit6 set
// - dac modulator divider runs only when bit4 set
// - bit3/bit2 enable primary/secondary bitclock dividers
// - bit1/bit0 enable primary/secondary framesync dividers
// - 3-bit code selects clock output source
// - clock output divider runs while bit7 set
// - clock output divides by code, zero means 128
// - two-bit frequency mode; 12MHz needs manually selected oscillator source
// - source auto-selected while bit5 is zero
// - manual source: audio clock or internal oscillator
// - divider auto-enabled while bit3 is zero
// - manual enable bit ignored in auto mode
// - manual ratio 1,2,4,8, ignored in auto mode
// - read-only overload status at 0x5b, resets zero
// - adc/dac/bit-clock divide values ignored under automatic clock detection
`timescale 1ns/1ps
module ccsc_top
  import ccsc_pkg::*;
#(
  parameter int DIV_W = 10
) (
  input  wire logic             clk_sys,            // 10 MHz system clock
  input  wire logic             rstn,               // async reset, active low
  input  wire logic             reg_wr,             // register write strobe
  input  wire logic             reg_rd,             // register read strobe
  input  wire logic [7:0]       reg_addr,           // register address
  input  wire logic [7:0]       reg_wdata,          // write data
  output logic      [7:0]       reg_rdata,          // read data, one cycle after reg_rd
  input  wire logic             pll_clk_in,         // pll output clock
  input  wire logic             primary_bclk_in,    // primary port bit clock
  input  wire logic             secondary_bclk_in,  // secondary port bit clock
  input  wire logic             ctrl_clk_in,        // control interface clock
  input  wire logic             osc_clk_in,         // internal oscillator clock
  input  wire logic             dsp_clk_in,         // dsp clock
  input  wire logic             audio_clk_in,       // audio clock for adc/dac
  input  wire logic             auto_detect_en,     // automatic clock detection active
  input  wire logic [DIV_W-1:0] auto_ratio,         // ratio chosen by detection
  input  wire logic [DIV_W-1:0] adc_mod_div_value,  // adc modulator ratio
  input  wire logic [DIV_W-1:0] dac_mod_div_value,  // dac modulator ratio
  input  wire logic [DIV_W-1:0] pri_bclk_div_value, // primary bit-clock ratio
  input  wire logic [DIV_W-1:0] sec_bclk_div_value, // secondary bit-clock ratio
  input  wire logic [DIV_W-1:0] pri_fs_div_value,   // primary frame-sync ratio
  input  wire logic [DIV_W-1:0] sec_fs_div_value,   // secondary frame-sync ratio
  input  wire logic             sar_auto_src_osc,   // detection picks oscillator
  input  wire logic             sar_auto_enable,    // detection enables converter divider
  input  wire logic [1:0]       sar_auto_div_code,  // detection divider code
  input  wire logic [1:0]       ovld_event,         // overload pulses, ch1 bit1, ch2 bit0
  input  wire logic [1:0]       ovld_live,          // live overload levels
  output logic                  adc_mod_clk,        // adc modulator clock
  output logic                  dac_mod_clk,        // dac modulator clock
  output logic                  primary_bclk_out,   // primary bit clock
  output logic                  secondary_bclk_out, // secondary bit clock
  output logic                  primary_fsync_out,  // primary frame sync
  output logic                  secondary_fsync_out,// secondary frame sync
  output logic                  gp_clk_out,         // general-purpose clock output
  output logic                  sar_clk_out,        // converter clock
  output logic      [1:0]       sar_freq_mode,      // converter frequency mode
  output logic                  sar_src_is_osc,     // converter uses oscillator
  output logic                  sar_div_active,     // converter divider enabled
  output logic                  sar_mode_invalid    // 12MHz mode without manual oscillator select
);

  // ==========================================================================
  // reset release
  logic rst_meta_r;
  logic rst_n;

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      rst_meta_r <= 1'b0;
      rst_n      <= 1'b0;
    end
    else
    begin
      rst_meta_r <= 1'b1;
      rst_n      <= rst_meta_r;
    end
  end

  // ==========================================================================
  // helpers
  function automatic logic [CLKOUT_RATIO_W-1:0] clkout_ratio(input logic [6:0] code);
    if (code == '0)
      clkout_ratio = CLKOUT_RATIO_ZERO;
    else
      clkout_ratio = {1'b0, code};
  endfunction

  function automatic logic [SAR_RATIO_W-1:0] pow2_ratio(input logic [1:0] code);
    pow2_ratio = {{(SAR_RATIO_W-1){1'b0}}, 1'b1} << code;
  endfunction

  // ==========================================================================
  // registers
  logic [7:0] div_enable_r;
  logic [7:0] clkout_src_r;
  logic [7:0] clock_output_divide_value_r;
  logic [7:0] conv_clk_r;
  logic [1:0] ovld_latch_r;
  logic       rd_ovld;

  assign rd_ovld = reg_rd && (reg_addr == OFS_ADC_OVLD);

  // reserved bits are masked so they store nothing and read zero
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      div_enable_r <= RST_DIV_ENABLE;
      clkout_src_r <= RST_CLKOUT_SRC;
      clock_output_divide_value_r <= RST_CLOCK_OUTPUT_DIVIDE_VALUE;
      conv_clk_r   <= RST_CONV_CLK;
    end
    else if (reg_wr)
    begin
      case (reg_addr)
        OFS_DIV_ENABLE: div_enable_r <= reg_wdata & MSK_DIV_ENABLE;
        OFS_CLKOUT_SRC: clkout_src_r <= reg_wdata & MSK_CLKOUT_SRC;
        OFS_CLOCK_OUTPUT_DIVIDE_VALUE: clock_output_divide_value_r <= reg_wdata & MSK_CLOCK_OUTPUT_DIVIDE_VALUE;
        OFS_CONV_CLK:   conv_clk_r   <= reg_wdata & MSK_CONV_CLK;
        default:        ;
      endcase
    end
  end

  // latched overload flags clear on read; a new event in the same cycle wins
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      ovld_latch_r <= RST_ADC_OVLD[BIT_OVLD_LATCH_LO+1:BIT_OVLD_LATCH_LO];
    else
      ovld_latch_r <= (rd_ovld ? 2'h0 : ovld_latch_r) | ovld_event;
  end

  // writes to the status address are ignored
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      reg_rdata <= 8'h00;
    else if (reg_rd)
    begin
      case (reg_addr)
        OFS_DIV_ENABLE: reg_rdata <= div_enable_r;
        OFS_CLKOUT_SRC: reg_rdata <= clkout_src_r;
        OFS_CLOCK_OUTPUT_DIVIDE_VALUE: reg_rdata <= clock_output_divide_value_r;
        OFS_CONV_CLK:   reg_rdata <= conv_clk_r;
        OFS_ADC_OVLD:   reg_rdata <= {ovld_latch_r, ovld_live, 4'h0};
        default:        reg_rdata <= 8'h00;
      endcase
    end
  end

  // ==========================================================================
  // source clock synchronisers
  logic [NUM_SRC-1:0] src_in;
  logic [NUM_SRC-1:0] src_tick;

  assign src_in = {audio_clk_in, dsp_clk_in, osc_clk_in, ctrl_clk_in,
                   secondary_bclk_in, primary_bclk_in, pll_clk_in};

  for (genvar g = 0; g < NUM_SRC; g++)
  begin : g_sync
    ccsc_sync u_sync (
      .clk_sys   (clk_sys),
      .rst_n     (rst_n),
      .async_in  (src_in[g]),
      .rise_tick (src_tick[g])
    );
  end

  // ==========================================================================
  // audio dividers: adc, dac, primary/secondary bit clock, primary/secondary frame sync
  logic [NUM_AUDIO_DIV-1:0] aud_en;
  logic [DIV_W-1:0]         aud_man [NUM_AUDIO_DIV];
  logic [NUM_AUDIO_DIV-1:0] aud_clk;

  assign aud_en = {div_enable_r[BIT_ADC_MOD_EN],
                   div_enable_r[BIT_DAC_MOD_EN],
                   div_enable_r[BIT_PRI_BCLK_EN],
                   div_enable_r[BIT_SEC_BCLK_EN],
                   div_enable_r[BIT_PRI_FS_EN],
                   div_enable_r[BIT_SEC_FS_EN]};

  assign aud_man[5] = adc_mod_div_value;
  assign aud_man[4] = dac_mod_div_value;
  assign aud_man[3] = pri_bclk_div_value;
  assign aud_man[2] = sec_bclk_div_value;
  assign aud_man[1] = pri_fs_div_value;
  assign aud_man[0] = sec_fs_div_value;

  for (genvar g = 0; g < NUM_AUDIO_DIV; g++)
  begin : g_aud
    logic [DIV_W-1:0] ratio;
    // frame-sync dividers keep their own value; the rest follow detection
    assign ratio = (auto_detect_en && (g >= NUM_AUDIO_DIV - NUM_AUTO_DIV))
                   ? auto_ratio : aud_man[g];
    ccsc_divider #(.RW(DIV_W)) u_div (
      .clk_sys   (clk_sys),
      .rst_n     (rst_n),
      .enable    (aud_en[g]),
      .tick      (src_tick[IDX_AUDIO]),
      .ratio     (ratio),
      .clk_out   (aud_clk[g]),
      .pulse_out ()
    );
  end

  assign adc_mod_clk         = aud_clk[5];
  assign dac_mod_clk         = aud_clk[4];
  assign primary_bclk_out    = aud_clk[3];
  assign secondary_bclk_out  = aud_clk[2];
  assign primary_fsync_out   = aud_clk[1];
  assign secondary_fsync_out = aud_clk[0];

  // ==========================================================================
  // general-purpose clock output
  logic [2:0]                clkout_sel;
  logic                      clkout_tick;
  logic [CLKOUT_RATIO_W-1:0] clkout_ratio_w;

  assign clkout_sel     = clkout_src_r[2:0];
  assign clkout_ratio_w = clkout_ratio(clock_output_divide_value_r[CLOCK_OUTPUT_DIVIDE_VALUE_W-1:0]);

  always_comb
  begin
    case (clkout_sel)
      CCSC_SRC_PLL:   clkout_tick = src_tick[CCSC_SRC_PLL];
      CCSC_SRC_PBCLK: clkout_tick = src_tick[CCSC_SRC_PBCLK];
      CCSC_SRC_SBCLK: clkout_tick = src_tick[CCSC_SRC_SBCLK];
      CCSC_SRC_CONTROL_INTERFACE_CLOCK:  clkout_tick = src_tick[CCSC_SRC_CONTROL_INTERFACE_CLOCK];
      CCSC_SRC_OSC:   clkout_tick = src_tick[CCSC_SRC_OSC];
      CCSC_SRC_DSP:   clkout_tick = src_tick[CCSC_SRC_DSP];
      default:        clkout_tick = 1'b0; // reserved codes give no clock
    endcase
  end

  ccsc_divider #(.RW(CLKOUT_RATIO_W)) u_clkout (
    .clk_sys   (clk_sys),
    .rst_n     (rst_n),
    .enable    (clock_output_divide_value_r[BIT_CLKOUT_EN]),
    .tick      (clkout_tick),
    .ratio     (clkout_ratio_w),
    .clk_out   (gp_clk_out),
    .pulse_out ()
  );

  // ==========================================================================
  // converter clock
  logic                   sar_auto_src;
  logic                   sar_auto_en;
  logic [SAR_RATIO_W-1:0] sar_ratio;
  logic                   sar_tick;

  assign sar_auto_src = !conv_clk_r[BIT_SRC_AUTO_DIS];
  assign sar_auto_en  = !conv_clk_r[BIT_EN_AUTO_DIS];
  assign sar_ratio    = sar_auto_en ? pow2_ratio(sar_auto_div_code)
                        : pow2_ratio(conv_clk_r[BIT_MAN_DIV_HI:BIT_MAN_DIV_LO]);

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sar_src_is_osc   <= 1'b0;
      sar_div_active   <= 1'b0;
      sar_freq_mode    <= 2'h0;
      sar_mode_invalid <= 1'b0;
    end
    else
    begin
      sar_src_is_osc <= sar_auto_src ? sar_auto_src_osc
                        : conv_clk_r[BIT_SRC_MAN_SEL];
      sar_div_active <= sar_auto_en ? sar_auto_enable
                        : conv_clk_r[BIT_MAN_EN];
      sar_freq_mode  <= conv_clk_r[BIT_FREQ_MODE_HI:BIT_FREQ_MODE_LO];
      // the fastest mode is only legal with the oscillator selected manually
      sar_mode_invalid <= (conv_clk_r[BIT_FREQ_MODE_HI:BIT_FREQ_MODE_LO] == FREQ_MODE_12M)
                          && (sar_auto_src || !conv_clk_r[BIT_SRC_MAN_SEL]);
    end
  end

  assign sar_tick = sar_src_is_osc ? src_tick[CCSC_SRC_OSC] : src_tick[IDX_AUDIO];

  ccsc_divider #(.RW(SAR_RATIO_W)) u_sar (
    .clk_sys   (clk_sys),
    .rst_n     (rst_n),
    .enable    (sar_div_active),
    .tick      (sar_tick),
    .ratio     (sar_ratio),
    .clk_out   (sar_clk_out),
    .pulse_out ()
  );

  // ==========================================================================
  // checks
  sequence s_write(logic [7:0] a);
    reg_wr && reg_addr == a;
  endsequence

  property p_adc_off;
    @(posedge clk_sys) disable iff (!rst_n)
    !div_enable_r[BIT_ADC_MOD_EN] |=> !adc_mod_clk;
  endproperty
  a_adc_off: assert property (p_adc_off) else $error("adc clock moves while disabled");

  property p_dac_off;
    @(posedge clk_sys) disable iff (!rst_n)
    !div_enable_r[BIT_DAC_MOD_EN] [*2] |-> !dac_mod_clk;
  endproperty
  a_dac_off: assert property (p_dac_off) else $error("dac clock moves while disabled");

  property p_bclk_en;
    @(posedge clk_sys) disable iff (!rst_n)
    s_write(OFS_DIV_ENABLE) ##1 1'b1
      |-> div_enable_r[BIT_PRI_BCLK_EN] == $past(reg_wdata[BIT_PRI_BCLK_EN]);
  endproperty
  a_bclk_en: assert property (p_bclk_en) else $error("bit clock enable not stored");

  property p_fs_off;
    @(posedge clk_sys) disable iff (!rst_n)
    !div_enable_r[BIT_SEC_FS_EN] |=> !secondary_fsync_out;
  endproperty
  a_fs_off: assert property (p_fs_off) else $error("frame sync moves while disabled");

  // a reserved source must freeze a running output, whatever level it was left at
  property p_clkout_src;
    @(posedge clk_sys) disable iff (!rst_n)
    (clkout_sel > CCSC_SRC_DSP && clock_output_divide_value_r[BIT_CLKOUT_EN]) [*2] |-> $stable(gp_clk_out);
  endproperty
  a_clkout_src: assert property (p_clkout_src) else $error("reserved source moves output");

  property p_clkout_off;
    @(posedge clk_sys) disable iff (!rst_n)
    s_write(OFS_CLOCK_OUTPUT_DIVIDE_VALUE) ##0 !reg_wdata[BIT_CLKOUT_EN] |=> ##1 !gp_clk_out;
  endproperty
  a_clkout_off: assert property (p_clkout_off) else $error("clock output not stopped");

  property p_clkout_zero;
    @(posedge clk_sys) disable iff (!rst_n)
    clock_output_divide_value_r[CLOCK_OUTPUT_DIVIDE_VALUE_W-1:0] == 7'h00 |-> clkout_ratio_w == CLKOUT_RATIO_ZERO;
  endproperty
  a_clkout_zero: assert property (p_clkout_zero) else $error("code zero not 128");

  property p_sar_auto_en;
    @(posedge clk_sys) disable iff (!rst_n)
    (sar_auto_en && sar_auto_enable) [*2] |-> sar_div_active;
  endproperty
  a_sar_auto_en: assert property (p_sar_auto_en) else $error("auto enable ignored");

  property p_ovld_ro;
    @(posedge clk_sys) disable iff (!rst_n)
    s_write(OFS_ADC_OVLD) ##0 (!reg_rd && ovld_event == 2'h0) |=> $stable(ovld_latch_r);
  endproperty
  a_ovld_ro: assert property (p_ovld_ro) else $error("status changed by write");

endmodule

// ===== test/test_ccsc_top.sv
// self-checking bench for the clock-tree configuration block.
// assumes every source clock comes from one bench divider: 8 clk_sys per period.
`timescale 1ns/1ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin miscompares++; \
  $display("[ERR] t=%0t got %h exp %h", $time, (a), (b)); end end
module test_ccsc_top;
  import ccsc_pkg::*;
  // ==========================================================================
  // stimulus and observed signals
  logic       clk_sys = 1'b0, rstn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, auto_en = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
  logic [9:0] dv = 10'h001, auto_ratio = 10'h001;
  logic       a_osc = 1'b0, a_en = 1'b0;
  logic [1:0] a_div = 2'h0, ov_ev = 2'h0, ov_live = 2'h0, fmode;
  logic       adc, dac, pb, sb, pf, sf, gp, sar, osc_sel, act, inval;
  logic [2:0] sc = 3'h0;
  int         miscompares = 0, n_tests = 0;
  // {address, write data, reset value, read-back}
  logic [31:0] rows [6] = '{32'h45ff005f, 32'h46ff0007, 32'h47830183, 32'h49170017,
                            32'h5bff0000, 32'h48ff0000};

  ccsc_top #(.DIV_W(10)) dut_u (
    .clk_sys(clk_sys), .rstn(rstn), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .pll_clk_in(sc[2]),
    .primary_bclk_in(sc[2]), .secondary_bclk_in(sc[2]), .ctrl_clk_in(sc[2]),
    .osc_clk_in(sc[2]), .dsp_clk_in(sc[2]), .audio_clk_in(sc[2]), .auto_detect_en(auto_en),
    .auto_ratio(auto_ratio), .adc_mod_div_value(dv), .dac_mod_div_value(dv),
    .pri_bclk_div_value(dv), .sec_bclk_div_value(dv), .pri_fs_div_value(dv),
    .sec_fs_div_value(dv), .sar_auto_src_osc(a_osc), .sar_auto_enable(a_en),
    .sar_auto_div_code(a_div), .ovld_event(ov_ev), .ovld_live(ov_live),
    .adc_mod_clk(adc), .dac_mod_clk(dac), .primary_bclk_out(pb), .secondary_bclk_out(sb),
    .primary_fsync_out(pf), .secondary_fsync_out(sf), .gp_clk_out(gp), .sar_clk_out(sar),
    .sar_freq_mode(fmode), .sar_src_is_osc(osc_sel), .sar_div_active(act),
    .sar_mode_invalid(inval));

  // ==========================================================================
  // clocks: phases of 4 cycles keep the sources above the synchroniser minimum
  initial forever #50 clk_sys = ~clk_sys;
  always @(posedge clk_sys) sc <= sc + 3'h1;

  // ==========================================================================
  // tasks
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  // cycles between 2nd and 3rd rising edge; the first period may be partial. 0 = none
  task automatic per(input int s, output int p);
    int   e;
    int   t0;
    logic pv;
    logic cv;
    p  = 0;
    e  = 0;
    t0 = 0;
    pv = 1'b1;
    for (int n = 0; n < 3300 && e < 3; n++)
    begin
      @(posedge clk_sys);
      #1 cv = (s == 0) ? gp : (s == 1) ? sar : adc;
      // an unknown level must not pass as a stopped clock
      if ($isunknown(cv))
      begin
        p = -1;
        e = 4;
      end
      else if (cv && !pv)
      begin
        e++;
        if (e == 2) t0 = n;
        if (e == 3) p = n - t0;
      end
      pv = cv;
    end
  endtask

  task automatic conclude;
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // ==========================================================================
  // sequence
  initial
  begin
    logic [7:0] d;
    int         p;
    repeat (3) @(posedge clk_sys);
    rstn <= 1'b1;
    repeat (3) @(posedge clk_sys);
    foreach (rows[i])
    begin
      rd(rows[i][31:24], d);
      `CHK(d, rows[i][15:8])
      wr(rows[i][31:24], rows[i][23:16]);
      rd(rows[i][31:24], d);
      `CHK(d, rows[i][7:0])
    end
    $display("register table done");
    // ratio 1 holds an enabled divider high, so each bit shows as a level
    for (int b = 0; b < 7; b++)
    begin
      wr(8'h45, 8'h01 << b);
      repeat (30) @(posedge clk_sys);
      #1 `CHK({adc, 1'b0, dac, pb, sb, pf, sf}, (b == 5) ? 7'h00 : 7'h01 << b)
    end
    @(posedge clk_sys);
    dv <= 10'h003;
    wr(8'h45, 8'h40);
    per(2, p);
    `CHK(p, 24)
    @(posedge clk_sys);
    auto_en    <= 1'b1;
    auto_ratio <= 10'h002;
    per(2, p);
    `CHK(p, 16)
    $display("divider enables done");
    wr(8'h47, 8'h83);
    for (int s = 0; s < 8; s++)
    begin
      wr(8'h46, s[7:0]);
      per(0, p);
      `CHK(p, (s < 6) ? 24 : 0)
    end
    wr(8'h46, 8'h00);
    wr(8'h47, 8'h80);
    per(0, p);
    `CHK(p, 1024)
    wr(8'h47, 8'h03);
    per(0, p);
    `CHK(p, 0)
    `CHK(gp, 1'b0)
    $display("clock output done");
    @(posedge clk_sys);
    a_osc <= 1'b1;
    a_en  <= 1'b1;
    a_div <= 2'h1;
    wr(8'h49, 8'hc0);
    repeat (5) @(posedge clk_sys);
    #1 `CHK({fmode, osc_sel, act, inval}, 5'h1f)
    per(1, p);
    `CHK(p, 16)
    wr(8'h49, 8'hfe);
    repeat (5) @(posedge clk_sys);
    #1 `CHK({fmode, osc_sel, act, inval}, 5'h1e)
    per(1, p);
    `CHK(p, 32)
    wr(8'h49, 8'h2b);
    repeat (5) @(posedge clk_sys);
    #1 `CHK({fmode, osc_sel, act, inval}, 5'h00)
    per(1, p);
    `CHK(p, 0)
    $display("converter clock done");
    @(posedge clk_sys);
    ov_live <= 2'h1;
    ov_ev   <= 2'h2;
    @(posedge clk_sys);
    ov_ev <= 2'h0;
    rd(8'h5b, d);
    `CHK(d, 8'h90)
    rd(8'h5b, d);
    `CHK(d, 8'h10)
    $display("status done");
    @(posedge clk_sys);
    rstn <= 1'b0;
    repeat (3) @(posedge clk_sys);
    #1 `CHK({adc, dac, pb, sb, pf, sf, gp, sar}, 8'h00)
    @(posedge clk_sys);
    rstn <= 1'b1;
    repeat (3) @(posedge clk_sys);
    rd(8'h47, d);
    `CHK(d, 8'h01)
    $display("second reset done");
    conclude;
  end

  // about 17k cycles expected; roughly three times that means a hang
  initial
  begin
    #5_000_000;
    miscompares++;
    $display("watchdog expired");
    conclude;
  end
endmodule
